// [logic/ldbpc_pkg.sv]
// Shared constants and types of the LED driver boost and protection configuration bank
`default_nettype none

package ldbpc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_DIM_OFS     = 8'h6E;
  localparam logic [7:0] FAULT_MASK_OFS   = 8'h6F;
  localparam logic [7:0] CONV_CLK_OFS     = 8'h70;
  localparam logic [7:0] CONV_RAMP_OFS    = 8'h71;
  localparam logic [7:0] IRQ_STATUS_OFS   = 8'h78;
  localparam logic [7:0] IRQ_ENABLE_OFS   = 8'h79;
  localparam logic [7:0] IRQ_CLEAR_OFS    = 8'h7A;

  // ----------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_DIM_WMASK   = 8'h1F;
  localparam logic [7:0] FAULT_MASK_WMASK = 8'hFF;
  localparam logic [7:0] CONV_CLK_WMASK   = 8'h3F;
  localparam logic [7:0] CONV_RAMP_WMASK  = 8'hFF;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [4:0] IRQ_RESET        = 5'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYNC_TYPE_BIT   = 4;
  localparam int DIM_FREQ_LSB    = 0;
  localparam int BOOST_OV_MASK   = 7;
  localparam int BOOST_OC_MASK   = 6;
  localparam int IN_OV_MASK      = 5;
  localparam int IN_UV_MASK      = 4;
  localparam int UV_SEL_LSB      = 2;
  localparam int OV_SEL_LSB      = 0;
  localparam int RAMP_DELAY_BIT  = 5;
  localparam int CLK_SRC_BIT     = 4;
  localparam int ILIM_LSB        = 1;
  localparam int GATE_SUPPLY_BIT = 0;
  localparam int SPREAD_BIT      = 7;
  localparam int IND_LSB         = 5;
  localparam int SLOPE_LSB       = 3;
  localparam int FREQ_LSB        = 0;

  // Interrupt status bit positions
  localparam int EV_BOOST_OV = 0;
  localparam int EV_BOOST_OC = 1;
  localparam int EV_IN_OV    = 2;
  localparam int EV_IN_UV    = 3;
  localparam int EV_CLK_LOST = 4;

  // ----------------------------------------------------------------
  // Threshold codes, units of 0.1 V; zero means detection off
  // ----------------------------------------------------------------
  localparam logic [8:0] THR_OFF  = 9'h000;
  localparam logic [8:0] UV_3V0   = 9'h01E;
  localparam logic [8:0] UV_5V0   = 9'h032;
  localparam logic [8:0] UV_8V0   = 9'h050;
  localparam logic [8:0] OV_7V0   = 9'h046;
  localparam logic [8:0] OV_11V0  = 9'h06E;
  localparam logic [8:0] OV_22V5  = 9'h0E1;

  // Current limit in amps: code plus this base
  localparam logic [3:0] ILIM_BASE_A = 4'h2;

  // Ramp delay as a percentage of the switching period
  localparam logic [6:0] RAMP_DELAY_PCT = 7'h23;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ             = 40_000_000;
  localparam int SS_MOD_MHZ         = 1_875_000;   // 1.875 kHz in mHz
  localparam int SS_STEPS           = 120;          // triangle steps per period
  localparam int SS_STEP_CYC        = (CLK_HZ / SS_STEPS) * 1000 / SS_MOD_MHZ;
  localparam logic [7:0] SS_STEP_LAST = 8'(SS_STEP_CYC - 1);
  localparam logic signed [6:0] SS_MAX = 7'sd30;   // +3.0 percent, 0.1 % units
  localparam logic [7:0] LOSS_NUM   = 8'h98;        // 1.52 periods = 152/100
  localparam logic [7:0] LOSS_DEN   = 8'h64;

  // State of the whole bank
  typedef struct packed {
    logic [7:0]        syncDim;
    logic [7:0]        faultMask;
    logic [7:0]        convClk;
    logic [7:0]        convRamp;
    logic [4:0]        irqEnable;
    logic [4:0]        irqStatus;
    logic [7:0]        rdData;
    logic              syncPrev;
    logic [15:0]       edgeCnt;
    logic [15:0]       period;
    logic              extLost;
    logic              faultPin;
    logic              recoveryReq;
    logic [7:0]        ssDiv;
    logic signed [6:0] ssVal;
    logic              ssUp;
  } ldbpc_state_t;

endpackage

`default_nettype wire

// [logic/ldbpc_top.sv]
// Configuration bank, fault gating and converter clock supervision of the LED driver
//
// How it works
// - bit 4 picks line or frame sync
// - bits 3:0 set internal-oscillator dimming frequency
// - bit 7 hides boost overvoltage flag, pin
// - bit 6 blocks recovery on boost overcurrent
// - bit 5 blocks recovery on input overvoltage
// - bit 4 blocks recovery on input undervoltage
// - undervoltage code: off, 3, 5, 8 V
// - overvoltage code: off, 7, 11, 22.5 V
// - bit 5 delays current ramp 35%
// - bit 4 chooses internal or external clock
// - missing sync 1.52 periods falls back internally
// - current limit 2 A to 9 A
// - bit 0 picks charge pump gate supply
// - spread spectrum +-3% at 1.875 kHz
// - slope and inductor fields index ramp table
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module ldbpc_top
  import ldbpc_pkg::*;
#(
  parameter logic [10:0] RAMP_MISSING_X10 = 11'h000  // Unprinted table cell
) (
  input  wire logic        clk,             // 40 MHz clock
  input  wire logic        arst_n,          // Asynchronous reset, active low
  input  wire logic [7:0]  regAddr,         // Register address
  input  wire logic [7:0]  regWrData,       // Register write data
  input  wire logic        regWr,           // Write strobe
  input  wire logic        regRd,           // Read strobe
  output logic      [7:0]  regRdData,       // Read data, cycle after strobe
  input  wire logic [8:0]  vinDeciV,        // Input voltage, 0.1 V units
  input  wire logic        boostOvDet,      // Boost overvoltage detected
  input  wire logic        boostOcDet,      // Boost overcurrent detected
  input  wire logic        dimIntOsc,       // Dimming clock is internal oscillator
  input  wire logic        convSyncIn,      // Converter sync pin
  output logic             syncFrameRate,   // 1 frame-rate sync, 0 line-rate
  output logic      [3:0]  dimmingFreqSel,  // Dimming frequency code
  output logic             dimmingFreqUse,  // Code is in force
  output logic      [8:0]  uvThreshDeciV,   // Undervoltage threshold, 0 off
  output logic      [8:0]  ovThreshDeciV,   // Overvoltage threshold, 0 off
  output logic             faultPin,        // Fault pin level
  output logic             recoveryReq,     // Enter fault recovery state
  output logic      [6:0]  rampDelayPct,    // Current ramp delay, % of period
  output logic             convClkExt,      // Converter runs on external clock
  output logic      [2:0]  convFreqSel,     // Internal switching frequency code
  output logic      [3:0]  currentLimitA,   // Peak current limit in amps
  output logic             gateSupplyPump,  // Gate driver from charge pump
  output logic signed [6:0] spreadDeciPct,  // Frequency offset, 0.1 % units
  output logic      [10:0] rampPeakX10,     // Ramp peak, tenths of table unit
  output logic             irq              // Level interrupt
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Undervoltage code to threshold
  function automatic logic [8:0] uv_decode(input logic [1:0] code);
    logic [8:0] v;
    v = THR_OFF;
    unique case (code)
      2'b00: v = THR_OFF;
      2'b01: v = UV_3V0;
      2'b10: v = UV_5V0;
      2'b11: v = UV_8V0;
    endcase
    return v;
  endfunction

  // Overvoltage code to threshold
  function automatic logic [8:0] ov_decode(input logic [1:0] code);
    logic [8:0] v;
    v = THR_OFF;
    unique case (code)
      2'b00: v = THR_OFF;
      2'b01: v = OV_7V0;
      2'b10: v = OV_11V0;
      2'b11: v = OV_22V5;
    endcase
    return v;
  endfunction

  // Ramp peak table, slope code by inductor code, tenths
  function automatic logic [10:0] ramp_lookup(input logic [1:0] slope,
                                              input logic [1:0] ind);
    logic [10:0] v;
    v = 11'h000;
    unique case ({slope, ind})
      4'h0: v = 11'h514;           // 130
      4'h1: v = 11'h28A;           // 65
      4'h2: v = 11'h154;           // 34
      4'h3: v = RAMP_MISSING_X10;
      4'h4: v = 11'h370;           // 88
      4'h5: v = 11'h1AE;           // 43
      4'h6: v = 11'h0E6;           // 23
      4'h7: v = 11'h0C8;           // 20
      4'h8: v = 11'h230;           // 56
      4'h9: v = 11'h118;           // 28
      4'hA: v = 11'h096;           // 15
      4'hB: v = 11'h096;           // 15
      4'hC: v = 11'h172;           // 37
      4'hD: v = 11'h0B4;           // 18
      4'hE: v = 11'h064;           // 10
      4'hF: v = 11'h055;           // 8.5
    endcase
    return v;
  endfunction

  // Masked write of a configuration byte
  function automatic logic [7:0] cfg_write(input logic [7:0] data,
                                           input logic [7:0] wmask);
    return data & wmask;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ldbpc_state_t st_reg;
  ldbpc_state_t st_next;

  logic       uvFault;
  logic       ovFault;
  logic       syncEdge;
  logic       extSel;
  logic [4:0] events;
  logic [8:0] uvThr;
  logic [8:0] ovThr;
  logic [23:0] lostLhs;
  logic [23:0] lostRhs;

  // Threshold decoding and comparisons
  assign uvThr   = uv_decode(st_reg.faultMask[UV_SEL_LSB +: 2]);
  assign ovThr   = ov_decode(st_reg.faultMask[OV_SEL_LSB +: 2]);
  assign uvFault = (uvThr != THR_OFF) && (vinDeciV < uvThr);
  assign ovFault = (ovThr != THR_OFF) && (vinDeciV > ovThr);

  // Sync edge and loss test; period scaled to compare 1.52 periods
  assign syncEdge = convSyncIn && !st_reg.syncPrev;
  assign extSel   = st_reg.convClk[CLK_SRC_BIT];
  assign lostLhs  = 24'(st_reg.edgeCnt) * 24'(LOSS_DEN);
  assign lostRhs  = 24'(st_reg.period) * 24'(LOSS_NUM);

  // Events feeding the interrupt status; masked boost overvoltage is silent
  always_comb begin
    events              = '0;
    events[EV_BOOST_OV] = boostOvDet && !st_reg.faultMask[BOOST_OV_MASK];
    events[EV_BOOST_OC] = boostOcDet;
    events[EV_IN_OV]    = ovFault;
    events[EV_IN_UV]    = uvFault;
    events[EV_CLK_LOST] = extSel && !st_reg.extLost && (st_reg.period != '0)
                          && (lostLhs > lostRhs);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.rdData = 8'h00;

    // Register writes; reserved bits are never stored
    if (regWr) begin
      unique case (regAddr)
        SYNC_DIM_OFS:   st_next.syncDim   = cfg_write(regWrData, SYNC_DIM_WMASK);
        FAULT_MASK_OFS: st_next.faultMask = cfg_write(regWrData, FAULT_MASK_WMASK);
        CONV_CLK_OFS:   st_next.convClk   = cfg_write(regWrData, CONV_CLK_WMASK);
        CONV_RAMP_OFS:  st_next.convRamp  = cfg_write(regWrData, CONV_RAMP_WMASK);
        IRQ_ENABLE_OFS: st_next.irqEnable = regWrData[4:0];
        IRQ_CLEAR_OFS:  st_next.irqStatus = st_reg.irqStatus & ~regWrData[4:0];
        default: ;
      endcase
    end

    // Sticky status; a new event wins over a clear in the same cycle
    st_next.irqStatus = st_next.irqStatus | events;

    // Read data for the next cycle; unmapped and write-only read zero
    if (regRd) begin
      unique case (regAddr)
        SYNC_DIM_OFS:   st_next.rdData = st_reg.syncDim;
        FAULT_MASK_OFS: st_next.rdData = st_reg.faultMask;
        CONV_CLK_OFS:   st_next.rdData = st_reg.convClk;
        CONV_RAMP_OFS:  st_next.rdData = st_reg.convRamp;
        IRQ_STATUS_OFS: st_next.rdData = {3'b000, st_reg.irqStatus};
        IRQ_ENABLE_OFS: st_next.rdData = {3'b000, st_reg.irqEnable};
        default:        st_next.rdData = 8'h00;
      endcase
    end

    // Fault pin follows the unmasked faults; recovery honours the masks
    st_next.faultPin    = events[EV_BOOST_OV] | boostOcDet | ovFault | uvFault;
    st_next.recoveryReq = (boostOcDet && !st_reg.faultMask[BOOST_OC_MASK])
                        | (ovFault    && !st_reg.faultMask[IN_OV_MASK])
                        | (uvFault    && !st_reg.faultMask[IN_UV_MASK]);

    // Sync period measurement; the count saturates rather than wraps
    st_next.syncPrev = convSyncIn;
    if (syncEdge) begin
      st_next.period  = st_reg.edgeCnt;
      st_next.edgeCnt = 16'h0001;
      st_next.extLost = 1'b0;
    end else if (st_reg.edgeCnt != 16'hFFFF) begin
      st_next.edgeCnt = st_reg.edgeCnt + 16'h0001;
    end
    if (events[EV_CLK_LOST]) begin
      st_next.extLost = 1'b1;
    end
    if (!extSel) begin
      st_next.extLost = 1'b0;
    end

    // Spread spectrum triangle; parks at centre when disabled
    if (!st_reg.convRamp[SPREAD_BIT]) begin
      st_next.ssDiv = 8'h00;
      st_next.ssVal = 7'sd0;
      st_next.ssUp  = 1'b1;
    end else if (st_reg.ssDiv == SS_STEP_LAST) begin
      st_next.ssDiv = 8'h00;
      if (st_reg.ssUp) begin
        st_next.ssVal = st_reg.ssVal + 7'sd1;
        st_next.ssUp  = (st_reg.ssVal + 7'sd1) != SS_MAX;
      end else begin
        st_next.ssVal = st_reg.ssVal - 7'sd1;
        st_next.ssUp  = (st_reg.ssVal - 7'sd1) == -SS_MAX;
      end
    end else begin
      st_next.ssDiv = st_reg.ssDiv + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.syncDim     <= CFG_RESET;
      st_reg.faultMask   <= CFG_RESET;
      st_reg.convClk     <= CFG_RESET;
      st_reg.convRamp    <= CFG_RESET;
      st_reg.irqEnable   <= IRQ_RESET;
      st_reg.irqStatus   <= IRQ_RESET;
      st_reg.rdData      <= 8'h00;
      st_reg.syncPrev    <= 1'b0;
      st_reg.edgeCnt     <= 16'h0000;
      st_reg.period      <= 16'h0000;
      st_reg.extLost     <= 1'b0;
      st_reg.faultPin    <= 1'b0;
      st_reg.recoveryReq <= 1'b0;
      st_reg.ssDiv       <= 8'h00;
      st_reg.ssVal       <= 7'sd0;
      st_reg.ssUp        <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Register bus and interrupt
  assign regRdData = st_reg.rdData;
  assign irq       = |(st_reg.irqStatus & st_reg.irqEnable);

  // Dimming control; the code matters only on the internal oscillator
  assign syncFrameRate  = st_reg.syncDim[SYNC_TYPE_BIT];
  assign dimmingFreqSel = st_reg.syncDim[DIM_FREQ_LSB +: 4];
  assign dimmingFreqUse = dimIntOsc;

  // Protection
  assign uvThreshDeciV = uvThr;
  assign ovThreshDeciV = ovThr;
  assign faultPin      = st_reg.faultPin;
  assign recoveryReq   = st_reg.recoveryReq;

  // Converter settings; the fallback keeps the internal frequency code live
  assign rampDelayPct   = st_reg.convClk[RAMP_DELAY_BIT] ? RAMP_DELAY_PCT : 7'h00;
  assign convClkExt     = extSel && !st_reg.extLost;
  assign convFreqSel    = st_reg.convRamp[FREQ_LSB +: 3];
  assign currentLimitA  = {1'b0, st_reg.convClk[ILIM_LSB +: 3]} + ILIM_BASE_A;
  assign gateSupplyPump = st_reg.convClk[GATE_SUPPLY_BIT];
  assign spreadDeciPct  = st_reg.ssVal;
  assign rampPeakX10    = ramp_lookup(st_reg.convRamp[SLOPE_LSB +: 2],
                                      st_reg.convRamp[IND_LSB +: 2]);

endmodule

`default_nettype wire

// [tb/ldbpc_asserts.sv]
// Port-level assertions of the configuration bank
`timescale 1ns/1ps
`default_nettype none

module ldbpc_asserts
  import ldbpc_pkg::*;
(
  input wire logic              clk,            // Clock
  input wire logic              arst_n,         // Reset, active low
  input wire logic [7:0]        regAddr,        // Address
  input wire logic [7:0]        regWrData,      // Write data
  input wire logic              regWr,          // Write strobe
  input wire logic              regRd,          // Read strobe
  input wire logic [7:0]        regRdData,      // Read data
  input wire logic [8:0]        vinDeciV,       // Input voltage
  input wire logic              boostOvDet,     // Boost overvoltage
  input wire logic              boostOcDet,     // Boost overcurrent
  input wire logic              syncFrameRate,  // Sync type
  input wire logic [3:0]        dimmingFreqSel, // Dimming code
  input wire logic [8:0]        uvThreshDeciV,  // UV threshold
  input wire logic [8:0]        ovThreshDeciV,  // OV threshold
  input wire logic              faultPin,       // Fault pin
  input wire logic              recoveryReq,    // Recovery request
  input wire logic [6:0]        rampDelayPct,   // Ramp delay
  input wire logic [3:0]        currentLimitA,  // Current limit
  input wire logic              gateSupplyPump, // Gate supply
  input wire logic signed [6:0] spreadDeciPct   // Spread offset
);
  logic [7:0] fmShadow;
  logic [7:0] ccShadow;

  // Shadow copies, since the checker cannot look inside the bank
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fmShadow <= 8'h00;
      ccShadow <= 8'h00;
    end else if (regWr) begin
      if (regAddr == FAULT_MASK_OFS) fmShadow <= regWrData;
      if (regAddr == CONV_CLK_OFS) ccShadow <= regWrData;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_wrSd;
    regWr && regAddr == SYNC_DIM_OFS;
  endsequence
  sequence s_wrFm;
    regWr && regAddr == FAULT_MASK_OFS;
  endsequence

  // Register fields reach their outputs one cycle after the write
  property p_syncDim;
    s_wrSd |=> syncFrameRate == $past(regWrData[4]) && dimmingFreqSel == $past(regWrData[3:0]);
  endproperty
  a_syncDim: assert property (p_syncDim) else $error("sync field wrong");
  property p_thrDec;
    s_wrFm |=> uvThreshDeciV == ($past(regWrData[3:2]) == 2'h0 ? 9'h000 :
      $past(regWrData[3:2]) == 2'h1 ? 9'h01E : $past(regWrData[3:2]) == 2'h2 ? 9'h032 : 9'h050)
      && ovThreshDeciV == ($past(regWrData[1:0]) == 2'h0 ? 9'h000 :
      $past(regWrData[1:0]) == 2'h1 ? 9'h046 : $past(regWrData[1:0]) == 2'h2 ? 9'h06E : 9'h0E1);
  endproperty
  a_thrDec: assert property (p_thrDec) else $error("threshold decode wrong");

  // Fault reporting and recovery gating, one cycle after the cause
  property p_boostOv;
    boostOvDet && !fmShadow[7] |=> faultPin;
  endproperty
  a_boostOv: assert property (p_boostOv) else $error("boost ov pin missing");
  property p_boostOc;
    boostOcDet |=> faultPin && (recoveryReq || $past(fmShadow[6]));
  endproperty
  a_boostOc: assert property (p_boostOc) else $error("boost oc handling wrong");
  property p_inOv;
    ovThreshDeciV != 9'h000 && vinDeciV > ovThreshDeciV
      |=> faultPin && (recoveryReq || $past(fmShadow[5]));
  endproperty
  a_inOv: assert property (p_inOv) else $error("input ov handling wrong");
  property p_inUv;
    uvThreshDeciV != 9'h000 && vinDeciV < uvThreshDeciV
      |=> faultPin && (recoveryReq || $past(fmShadow[4]));
  endproperty
  a_inUv: assert property (p_inUv) else $error("input uv handling wrong");

  // Converter settings follow the stored register at all times
  property p_convCfg;
    rampDelayPct == (ccShadow[5] ? 7'h23 : 7'h00) && gateSupplyPump == ccShadow[0]
      && currentLimitA == {1'b0, ccShadow[3:1]} + 4'h2;
  endproperty
  a_convCfg: assert property (p_convCfg) else $error("converter field wrong");
  property p_rsvd;
    regRd && regAddr == SYNC_DIM_OFS |=> regRdData[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_spread;
    spreadDeciPct <= 7'sh1E && spreadDeciPct >= -7'sh1E;
  endproperty
  a_spread: assert property (p_spread) else $error("spread out of range");
endmodule

bind ldbpc_top ldbpc_asserts u_chk (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .vinDeciV(vinDeciV),
  .boostOvDet(boostOvDet), .boostOcDet(boostOcDet), .syncFrameRate(syncFrameRate),
  .dimmingFreqSel(dimmingFreqSel), .uvThreshDeciV(uvThreshDeciV),
  .ovThreshDeciV(ovThreshDeciV), .faultPin(faultPin), .recoveryReq(recoveryReq),
  .rampDelayPct(rampDelayPct), .currentLimitA(currentLimitA),
  .gateSupplyPump(gateSupplyPump), .spreadDeciPct(spreadDeciPct)
);
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the configuration bank
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ldbpc_pkg::*;
();
  logic clk, arst_n, regWr, regRd, boostOvDet, boostOcDet, dimIntOsc, convSyncIn;
  logic syncFrameRate, dimmingFreqUse, faultPin, recoveryReq, convClkExt, gateSupplyPump, irq;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [8:0] vinDeciV, uvThreshDeciV, ovThreshDeciV;
  logic [3:0] dimmingFreqSel, currentLimitA;
  logic [6:0] rampDelayPct;
  logic [2:0] convFreqSel;
  logic signed [6:0] spreadDeciPct;
  logic [10:0] rampPeakX10;
  logic [8:0] uvTab [4] = '{9'h000, 9'h01E, 9'h032, 9'h050};
  logic [8:0] ovTab [4] = '{9'h000, 9'h046, 9'h06E, 9'h0E1};
  logic [7:0] rampW [3] = '{8'h05, 8'h0B, 8'h7E};
  logic [10:0] rampE [3] = '{11'h514, 11'h370, 11'h055};
  int err_total = 0;
  int compares = 0;

  ldbpc_top u_dut (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .vinDeciV(vinDeciV), .boostOvDet(boostOvDet),
    .boostOcDet(boostOcDet), .dimIntOsc(dimIntOsc), .convSyncIn(convSyncIn),
    .syncFrameRate(syncFrameRate), .dimmingFreqSel(dimmingFreqSel),
    .dimmingFreqUse(dimmingFreqUse), .uvThreshDeciV(uvThreshDeciV),
    .ovThreshDeciV(ovThreshDeciV), .faultPin(faultPin), .recoveryReq(recoveryReq),
    .rampDelayPct(rampDelayPct), .convClkExt(convClkExt), .convFreqSel(convFreqSel),
    .currentLimitA(currentLimitA), .gateSupplyPump(gateSupplyPump),
    .spreadDeciPct(spreadDeciPct), .rampPeakX10(rampPeakX10), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Write strobe for one cycle; outputs settle before returning
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  // Read data only stands in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    cmp({3'h0, regRdData}, {3'h0, e}, "read");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Clock source, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard: the run needs about 22k cycles, mostly one spread period
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic signed [6:0] hi;
    logic signed [6:0] lo;
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    vinDeciV = 9'h032;
    boostOvDet = 1'b0;
    boostOcDet = 1'b0;
    dimIntOsc = 1'b1;
    convSyncIn = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(SYNC_DIM_OFS + 8'(a), 8'h00);
    cmp(rampPeakX10, 11'h514, "peak rst");
    cmp(11'(currentLimitA), 11'h002, "ilim rst");
    $display("[END] reset values");
    wr(SYNC_DIM_OFS, 8'hFF);
    rd(SYNC_DIM_OFS, 8'h1F);
    cmp(11'(syncFrameRate), 11'h001, "frame");
    cmp(11'(dimmingFreqSel), 11'h00F, "dim");
    cmp(11'(dimmingFreqUse), 11'h001, "dim use");
    wr(SYNC_DIM_OFS, 8'hE5);
    cmp(11'(syncFrameRate), 11'h000, "line");
    cmp(11'(dimmingFreqSel), 11'h005, "dim");
    @(posedge clk);
    dimIntOsc <= 1'b0;
    @(posedge clk);
    #1;
    cmp(11'(dimmingFreqUse), 11'h000, "dim use");
    $display("[END] sync and dimming");
    for (int k = 0; k < 8; k++) begin
      logic [2:0] c;
      c = 3'(k);
      d = {2'b11, c[0], 1'b0, c, c[0]};
      wr(CONV_CLK_OFS, d);
      rd(CONV_CLK_OFS, d & 8'h3F);
      cmp(11'(currentLimitA), 11'(c) + 11'h002, "ilim");
      cmp(11'(rampDelayPct), c[0] ? 11'h023 : 11'h000, "delay");
      cmp(11'(gateSupplyPump), 11'(c[0]), "gate");
      cmp(11'(convClkExt), 11'h000, "clk int");
    end
    for (int k = 0; k < 3; k++) begin
      wr(CONV_RAMP_OFS, rampW[k]);
      cmp(rampPeakX10, rampE[k], "peak");
      cmp(11'(convFreqSel), 11'(rampW[k][2:0]), "freq");
    end
    for (int k = 0; k < 4; k++) begin
      wr(FAULT_MASK_OFS, 8'(k * 5));
      cmp(11'(uvThreshDeciV), 11'(uvTab[k]), "uv thr");
      cmp(11'(ovThreshDeciV), 11'(ovTab[k]), "ov thr");
    end
    $display("[END] converter and thresholds");
    wr(FAULT_MASK_OFS, 8'h05);
    wr(IRQ_ENABLE_OFS, 8'h02);
    wr(IRQ_CLEAR_OFS, 8'h1F);
    rd(IRQ_ENABLE_OFS, 8'h02);
    rd(IRQ_CLEAR_OFS, 8'h00);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(FAULT_MASK_OFS, 8'h05 | (8'(m) << (7 - i)));
        @(posedge clk);
        boostOvDet <= (i == 0);
        boostOcDet <= (i == 1);
        vinDeciV <= (i == 2) ? 9'h064 : (i == 3) ? 9'h00A : 9'h032;
        @(posedge clk);
        #1;
        cmp(11'(faultPin), (i == 0 && m == 1) ? 11'h000 : 11'h001, "pin");
        cmp(11'(recoveryReq), (i == 0 || m == 1) ? 11'h000 : 11'h001, "recov");
        cmp(11'(irq), (i == 1) ? 11'h001 : 11'h000, "irq");
        rd(IRQ_STATUS_OFS, (i == 0 && m == 1) ? 8'h00 : 8'(1 << i));
        @(posedge clk);
        boostOvDet <= 1'b0;
        boostOcDet <= 1'b0;
        vinDeciV <= 9'h032;
        wr(IRQ_CLEAR_OFS, 8'h1F);
        rd(IRQ_STATUS_OFS, 8'h00);
        cmp(11'(irq), 11'h000, "irq clr");
      end
    end
    wr(FAULT_MASK_OFS, 8'h00);
    $display("[END] faults and interrupt");
    wr(CONV_CLK_OFS, 8'h10);
    cmp(11'(convClkExt), 11'h001, "clk ext");
    repeat (4) begin
      repeat (99) @(posedge clk);
      convSyncIn <= 1'b1;
      @(posedge clk);
      convSyncIn <= 1'b0;
    end
    repeat (140) @(posedge clk);
    #1;
    cmp(11'(convClkExt), 11'h001, "still ext");
    repeat (20) @(posedge clk);
    #1;
    cmp(11'(convClkExt), 11'h000, "fallback");
    rd(IRQ_STATUS_OFS, 8'h10);
    wr(IRQ_CLEAR_OFS, 8'h1F);
    $display("[END] clock fallback");
    wr(CONV_RAMP_OFS, 8'h80);
    hi = 7'sh00;
    lo = 7'sh00;
    // One full modulation period is 120 steps of 177 cycles
    repeat (21400) begin
      @(posedge clk);
      #1;
      if (spreadDeciPct > hi) hi = spreadDeciPct;
      if (spreadDeciPct < lo) lo = spreadDeciPct;
    end
    cmp({4'h0, hi}, 11'h01E, "ss max");
    cmp({4'h0, lo}, 11'h062, "ss min");
    wr(CONV_RAMP_OFS, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    cmp({4'h0, spreadDeciPct}, 11'h000, "ss off");
    $display("[END] spread spectrum");
    tally_and_finish();
  end
endmodule
`default_nettype wire
